/* File: include/flash_pkg.sv */
/*
  Constants, register map and types for the flash command and status block.
  Assumes a 32-bit AXI4-Lite register bus and an 8 KB byte-wide flash array.
*/
package flash_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int ARR_AW = 13;
  localparam int REG_W = 8;

  // ------------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------------
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_COMMAND = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_CLKDIV = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_PROT = 8'h0c;
  localparam logic [AXI_AW-1:0] OFS_ADDR = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_DATA = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_SEC = 8'h18;

  // ------------------------------------------------------------------
  // status and protection fields
  // ------------------------------------------------------------------
  localparam int BIT_CBEF = 7;
  localparam int BIT_CCF = 6;
  localparam int BIT_PVIOL = 5;
  localparam int BIT_ACCERR = 4;
  localparam int BIT_BLANK = 2;
  localparam int BIT_PDIS = 0;
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 7;
  localparam logic [5:0] PS_FILL = 6'h3f;

  // ------------------------------------------------------------------
  // command codes and values
  // ------------------------------------------------------------------
  localparam logic [REG_W-1:0] CMD_BLANK = 8'h05;
  localparam logic [REG_W-1:0] CMD_BYTE = 8'h20;
  localparam logic [REG_W-1:0] CMD_BURST = 8'h25;
  localparam logic [REG_W-1:0] CMD_PAGE = 8'h40;
  localparam logic [REG_W-1:0] CMD_MASS = 8'h41;
  localparam logic [REG_W-1:0] ERASED_BYTE = 8'hff;
  localparam logic [ARR_AW-1:0] ARR_FIRST = 13'h0000;
  localparam logic [ARR_AW-1:0] ARR_LAST = 13'h1fff;
  localparam logic [ARR_AW-1:0] ARR_STEP = 13'h0001;

  // ------------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------------
  localparam logic [REG_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [REG_W-1:0] PROT_RESET = 8'h01;
  localparam logic [ARR_AW-1:0] ADDR_RESET = 13'h0000;
  localparam logic [1:0] SEC_RESET = 2'h3;
  localparam logic [1:0] SEC_UNSECURED = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [AXI_DW-1:0] RDATA_ZERO = 32'h0000_0000;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ARR_READ, ARR_PROG, ARR_ERASE_PAGE, ARR_ERASE_MASS
  } arr_op_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} seq_t;

  typedef enum logic [1:0] {ENG_IDLE, ENG_ACCESS} eng_t;

endpackage

/* File: include/op_if.sv */
/*
  Command hand-off between the status/launch logic and the array engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface op_if;
  import flash_pkg::*;
  logic start;
  logic [REG_W-1:0] cmd;
  logic [ARR_AW-1:0] addr;
  logic [REG_W-1:0] data;
  logic busy;
  logic done;
  logic blank;
  modport ctrl (output start, cmd, addr, data, input busy, done, blank);
  modport engine (input start, cmd, addr, data, output busy, done, blank);
endinterface

/* File: rtl/flash_array_engine.sv */
/*
  Array engine: runs one flash command on the array pins.
  Assumes the array answers each arr_req with arr_ack (valid/ready style).
*/
`timescale 1ns/1ns
module flash_array_engine (
  input wire logic aclk,
  input wire logic aresetn,
  op_if.engine opp,
  output logic arr_req,
  output flash_pkg::arr_op_t arr_op,
  output logic [flash_pkg::ARR_AW-1:0] arr_addr,
  output logic [flash_pkg::REG_W-1:0] arr_wdata,
  input wire logic [flash_pkg::REG_W-1:0] arr_rdata,
  input wire logic arr_ack
);
  import flash_pkg::*;

  eng_t state_r;
  logic all_ff_r;
  logic busy_r;
  logic done_r;
  logic blank_r;
  logic last_byte;
  logic byte_ok;

  assign last_byte = (arr_addr == ARR_LAST);
  assign byte_ok = (arr_rdata == ERASED_BYTE);
  assign opp.busy = busy_r;
  assign opp.done = done_r;
  assign opp.blank = blank_r;

  // ------------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ENG_IDLE;
      arr_req <= 1'b0;
      arr_op <= ARR_READ;
      arr_addr <= ADDR_RESET;
      arr_wdata <= ZERO_BYTE;
      all_ff_r <= 1'b1;
    end else begin
      case (state_r)
        ENG_IDLE: begin
          if (opp.start) begin
            state_r <= ENG_ACCESS;
            arr_req <= 1'b1;
            arr_addr <= opp.addr;
            arr_wdata <= opp.data;
            all_ff_r <= 1'b1;
            case (opp.cmd)
              CMD_BLANK: begin
                arr_op <= ARR_READ;
                arr_addr <= ARR_FIRST;
              end
              CMD_PAGE: arr_op <= ARR_ERASE_PAGE;
              CMD_MASS: arr_op <= ARR_ERASE_MASS;
              default: arr_op <= ARR_PROG;
            endcase
          end
        end
        ENG_ACCESS: begin
          if (arr_ack) begin
            if (arr_op == ARR_READ && !byte_ok) begin
              all_ff_r <= 1'b0;
            end
            if (arr_op == ARR_READ && !last_byte) begin
              arr_addr <= arr_addr + ARR_STEP;
            end else begin
              arr_req <= 1'b0;
              state_r <= ENG_IDLE;
            end
          end
        end
        default: state_r <= ENG_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // completion report
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      blank_r <= 1'b0;
    end else begin
      done_r <= (state_r == ENG_ACCESS) && arr_ack
        && !(arr_op == ARR_READ && !last_byte);
      blank_r <= (state_r == ENG_ACCESS) && arr_ack
        && arr_op == ARR_READ && last_byte && all_ff_r && byte_ok;
      if (state_r == ENG_IDLE && opp.start) begin
        busy_r <= 1'b1;
      end else if (done_r) begin
        busy_r <= 1'b0;
      end
    end
  end

endmodule

/* File: rtl/flash_command_status_control.sv */
/*
  Flash command launch, status flags and command decode behind AXI4-Lite.
  Assumes a synchronous active-low reset and an array that acknowledges
  each request; divider, protection and security state live here too.
*/
// Our own choices: register access over AXI4-Lite and the register offsets.
// Behaviour
// - writing one to status bit 7 launches the prepared command.
// - only burst-program commands may wait in the buffer while busy.
// - buffer-empty reads 0 while the buffer is full, else 1.
// - command-complete (bit 6) is 1 when buffer empty and engine idle.
// - command-complete clears on a valid launch; writes to it do nothing.
// - program or erase of a protected location is dropped, sets bit 5.
// - protection-violation clears only by writing one to it.
// - wrong command-writing order sets access-error (bit 4), drops command.
// - program or erase before the divider is written sets access-error.
// - stop request while a command is in progress sets access-error.
// - access-error clears by writing one; writing zero leaves it.
// - blank check ends with bit 2 set only if all bytes read 0xff.
// - blank flag clears on a valid launch; writes to it do nothing.
// - codes 0x05 blank check, 0x20 byte program, 0x25 burst program.
// - codes 0x40 page erase of 512 bytes, 0x41 mass erase.
// - any other command code is rejected with access-error.
// - with protect-disable 0 the selected block is protected.
// - successful blank check sets security code to unsecured 1:0.
`timescale 1ns/1ns
module flash_command_status_control (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [flash_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [flash_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [flash_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [flash_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_req,
  output logic arr_req,
  output flash_pkg::arr_op_t arr_op,
  output logic [flash_pkg::ARR_AW-1:0] arr_addr,
  output logic [flash_pkg::REG_W-1:0] arr_wdata,
  input wire logic [flash_pkg::REG_W-1:0] arr_rdata,
  input wire logic arr_ack,
  output logic [1:0] security_state_code
);
  import flash_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [REG_W-1:0] flash_clock_divider_r;
  logic div_written_r;
  logic [REG_W-1:0] prot_r;
  logic [ARR_AW-1:0] addr_r;
  logic [REG_W-1:0] data_r;
  logic [REG_W-1:0] flash_command_r;
  seq_t seq_r;
  logic buf_full_r;
  logic [REG_W-1:0] buf_cmd_r;
  logic [ARR_AW-1:0] buf_addr_r;
  logic [REG_W-1:0] buf_data_r;
  logic start_r;
  logic protection_violation_flag_r;
  logic access_error_flag_r;
  logic blank_verified_flag_r;
  logic [1:0] sec_r;

  logic wr_en;
  logic wr_go;
  logic rd_en;
  logic wr_status;
  logic wr_cmd;
  logic wr_data;
  logic launch;
  logic legal;
  logic need_div;
  logic prot_hit;
  logic buf_ok;
  logic seq_ok;
  logic accept;
  logic acc_set;
  logic pv_set;
  logic cmd_busy;
  logic cmd_buffer_empty_flag;
  logic cmd_complete_flag;
  logic wr_known;
  logic rd_known;
  logic [REG_W-1:0] rd_byte;
  logic [REG_W-1:0] flash_status;

  op_if op_bus ();

  flash_array_engine u_engine (
    .aclk (aclk),
    .aresetn (aresetn),
    .opp (op_bus.engine),
    .arr_req (arr_req),
    .arr_op (arr_op),
    .arr_addr (arr_addr),
    .arr_wdata (arr_wdata),
    .arr_rdata (arr_rdata),
    .arr_ack (arr_ack)
  );

  assign op_bus.start = start_r;
  assign op_bus.cmd = buf_cmd_r;
  assign op_bus.addr = buf_addr_r;
  assign op_bus.data = buf_data_r;
  assign security_state_code = sec_r;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  assign wr_en = s_axi_awvalid && s_axi_wvalid && !s_axi_awready
    && !s_axi_bvalid;
  assign wr_go = wr_en && s_axi_wstrb[0];
  assign rd_en = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wr_status = wr_go && (s_axi_awaddr == OFS_STATUS);
  assign wr_cmd = wr_go && (s_axi_awaddr == OFS_COMMAND);
  assign wr_data = wr_go && (s_axi_awaddr == OFS_DATA);
  assign wr_known = (s_axi_awaddr == OFS_STATUS)
    || (s_axi_awaddr == OFS_COMMAND) || (s_axi_awaddr == OFS_CLKDIV)
    || (s_axi_awaddr == OFS_PROT) || (s_axi_awaddr == OFS_ADDR)
    || (s_axi_awaddr == OFS_DATA) || (s_axi_awaddr == OFS_SEC);

  // ------------------------------------------------------------------
  // command checks
  // ------------------------------------------------------------------
  assign launch = wr_status && s_axi_wdata[BIT_CBEF];
  assign legal = (flash_command_r == CMD_BLANK)
    || (flash_command_r == CMD_BYTE) || (flash_command_r == CMD_BURST)
    || (flash_command_r == CMD_PAGE)
    || (flash_command_r == CMD_MASS);
  assign need_div = (flash_command_r != CMD_BLANK);
  assign prot_hit = need_div && !prot_r[BIT_PDIS]
    && ((flash_command_r == CMD_MASS)
    || (addr_r > {prot_r[PS_MSB:PS_LSB], PS_FILL}));
  assign cmd_busy = op_bus.busy || start_r;
  assign buf_ok = !buf_full_r
    && (!cmd_busy || flash_command_r == CMD_BURST);
  assign seq_ok = (seq_r == SEQ_CMD) && buf_ok;
  assign pv_set = launch && seq_ok && legal
    && !(need_div && !div_written_r) && prot_hit;
  assign accept = launch && seq_ok && legal
    && !(need_div && !div_written_r) && !prot_hit;
  assign acc_set = (launch && (!seq_ok || !legal
    || (need_div && !div_written_r)))
    || (wr_cmd && seq_r != SEQ_DATA)
    || (wr_data && seq_r == SEQ_CMD)
    || (stop_req && (cmd_busy || buf_full_r));

  assign cmd_buffer_empty_flag = !buf_full_r;
  assign cmd_complete_flag = !buf_full_r && !cmd_busy;
  assign flash_status = {cmd_buffer_empty_flag, cmd_complete_flag,
    protection_violation_flag_r, access_error_flag_r, 1'b0,
    blank_verified_flag_r, 2'b00};

  // ------------------------------------------------------------------
  // write sequence tracking
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r <= SEQ_IDLE;
    end else begin
      case (seq_r)
        SEQ_IDLE, SEQ_DATA: begin
          if (wr_data) begin
            seq_r <= SEQ_DATA;
          end else if (wr_cmd && seq_r == SEQ_DATA) begin
            seq_r <= SEQ_CMD;
          end else if (launch || wr_cmd) begin
            seq_r <= SEQ_IDLE;
          end
        end
        SEQ_CMD: begin
          if (launch || wr_data || wr_cmd) begin
            seq_r <= SEQ_IDLE;
          end
        end
        default: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_clock_divider_r <= ZERO_BYTE;
      div_written_r <= 1'b0;
      prot_r <= PROT_RESET;
      addr_r <= ADDR_RESET;
      data_r <= ZERO_BYTE;
      flash_command_r <= ZERO_BYTE;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        OFS_CLKDIV: begin
          flash_clock_divider_r <= s_axi_wdata[REG_W-1:0];
          div_written_r <= 1'b1;
        end
        OFS_PROT: prot_r <= s_axi_wdata[REG_W-1:0];
        OFS_ADDR: addr_r <= s_axi_wdata[ARR_AW-1:0];
        OFS_DATA: data_r <= s_axi_wdata[REG_W-1:0];
        OFS_COMMAND: begin
          if (seq_r == SEQ_DATA) begin
            flash_command_r <= s_axi_wdata[REG_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // command buffer and engine hand-off
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buf_full_r <= 1'b0;
      buf_cmd_r <= ZERO_BYTE;
      buf_addr_r <= ADDR_RESET;
      buf_data_r <= ZERO_BYTE;
      start_r <= 1'b0;
    end else begin
      start_r <= buf_full_r && !op_bus.busy && !start_r;
      if (start_r) begin
        buf_full_r <= 1'b0;
      end else if (accept) begin
        buf_full_r <= 1'b1;
        buf_cmd_r <= flash_command_r;
        buf_addr_r <= addr_r;
        buf_data_r <= data_r;
      end
    end
  end

  // ------------------------------------------------------------------
  // sticky flags, set wins over clear
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protection_violation_flag_r <= 1'b0;
      access_error_flag_r <= 1'b0;
    end else begin
      protection_violation_flag_r <= pv_set || (protection_violation_flag_r
        && !(wr_status && s_axi_wdata[BIT_PVIOL]));
      access_error_flag_r <= acc_set || (access_error_flag_r
        && !(wr_status && s_axi_wdata[BIT_ACCERR]));
    end
  end

  // ------------------------------------------------------------------
  // blank result and security state
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blank_verified_flag_r <= 1'b0;
      sec_r <= SEC_RESET;
    end else begin
      if (op_bus.done && op_bus.blank) begin
        blank_verified_flag_r <= 1'b1;
        sec_r <= SEC_UNSECURED;
      end else if (accept) begin
        blank_verified_flag_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // axi write channel
  // ------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= wr_en;
      s_axi_wready <= wr_en;
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // axi read channel
  // ------------------------------------------------------------------
  always_comb begin
    rd_known = 1'b1;
    case (s_axi_araddr)
      OFS_STATUS: rd_byte = flash_status;
      OFS_COMMAND: rd_byte = flash_command_r;
      OFS_CLKDIV: rd_byte = flash_clock_divider_r;
      OFS_PROT: rd_byte = prot_r;
      OFS_ADDR: rd_byte = addr_r[REG_W-1:0];
      OFS_DATA: rd_byte = data_r;
      OFS_SEC: rd_byte = {6'h00, sec_r};
      default: begin
        rd_byte = ZERO_BYTE;
        rd_known = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RDATA_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= rd_en;
      if (rd_en) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
        if (s_axi_araddr == OFS_ADDR) begin
          s_axi_rdata <= {19'h00000, addr_r};
        end else begin
          s_axi_rdata <= {24'h000000, rd_byte};
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

/* File: tb/flash_array_model.sv */
/*
  behavioural flash array of 8 kB bytes, answers after lat idle cycles.
  assumes the block holds each request until it sees the ack.
*/
`timescale 1ns/1ns
module flash_array_model (
  input wire logic aclk,
  input wire logic [7:0] lat,
  input wire logic arr_req,
  input wire flash_pkg::arr_op_t arr_op,
  input wire logic [12:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  output logic [7:0] arr_rdata,
  output logic arr_ack
);
  import flash_pkg::*;
  logic [7:0] mem [0:8191];
  logic [7:0] cnt_r;
  initial begin
    arr_ack = 1'b0;
    arr_rdata = 8'h00;
    cnt_r = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // --
  // answer; read line toggles when not answering
  // --
  always @(posedge aclk) begin
    arr_rdata <= ~arr_rdata;
    arr_ack <= 1'b0;
    if (arr_req && !arr_ack) begin
      cnt_r <= cnt_r + 8'h01;
      if (cnt_r >= lat) begin
        cnt_r <= 8'h00;
        arr_ack <= 1'b1;
        arr_rdata <= mem[arr_addr];
      end
    end
  end
  // --
  // array contents
  // --
  always @(posedge aclk) begin
    if (arr_req && arr_ack) begin
      case (arr_op)
        ARR_PROG: mem[arr_addr] <= mem[arr_addr] & arr_wdata;
        ARR_ERASE_PAGE:
          for (int i = 0; i < 512; i++)
            mem[{arr_addr[12:9], i[8:0]}] <= 8'hff;
        ARR_ERASE_MASS: foreach (mem[i]) mem[i] <= 8'hff;
        default: ;
      endcase
    end
  end
endmodule

/* File: tb/flash_command_status_control_bench.sv */
/*
  bench for the flash command/status block with an array model.
  assumes the block answers each AXI4-Lite request a cycle after taking it.
*/
`timescale 1ns/1ns
module flash_command_status_control_bench;
  import flash_pkg::*;
  logic aclk, aresetn, stop_req, arr_req, arr_ack;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, arr_wdata, arr_rdata, lat;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, security_state_code, r;
  logic [12:0] arr_addr;
  arr_op_t arr_op;
  int mismatches, n_tests, cyc;
  flash_command_status_control flash_command_status_control_inst (.*);
  flash_array_model flash_array_model_inst (.*);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // --
  // bus tasks
  // --
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic st(input logic [7:0] e);
    rd(OFS_STATUS);
    chk(d, {24'h0, e});
  endtask
  task automatic go(input logic [7:0] c, input logic [12:0] a);
    wr(OFS_ADDR, {19'h0, a});
    wr(OFS_DATA, 32'h5a);
    wr(OFS_COMMAND, {24'h0, c});
    wr(OFS_STATUS, 32'h80);
  endtask
  task automatic fin(input logic [7:0] e);
    do rd(OFS_STATUS); while (d[6] !== 1'b1);
    chk(d, {24'h0, e});
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // --
  // tests
  // --
  initial begin
    aresetn = 1'b0;
    stop_req = 1'b0;
    lat = 8'h00;
    s_axi_awaddr = 8'h00;
    s_axi_awprot = 3'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arprot = 3'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    st(8'hc0);
    chk({30'h0, security_state_code}, 32'h3);
    rd(8'h1c);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(8'h1c, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    go(CMD_BYTE, 13'h5);
    fin(8'hd0);
    wr(OFS_STATUS, 32'h40);
    st(8'hd0);
    wr(OFS_STATUS, 32'h10);
    st(8'hc0);
    wr(OFS_CLKDIV, 32'h13);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
    go(8'h33, 13'h0);
    fin(8'hd0);
    wr(OFS_STATUS, 32'h10);
    wr(OFS_COMMAND, 32'h20);
    wr(OFS_STATUS, 32'h80);
    st(8'hd0);
    wr(OFS_STATUS, 32'h10);
    go(CMD_BLANK, 13'h0);
    fin(8'hc0);
    go(CMD_MASS, 13'h0);
    fin(8'hc0);
    go(CMD_BLANK, 13'h0);
    fin(8'hc4);
    chk({30'h0, security_state_code}, 32'h2);
    rd(OFS_SEC);
    chk(d, {30'h0, SEC_UNSECURED});
    wr(OFS_STATUS, 32'h04);
    st(8'hc4);
    go(CMD_BYTE, 13'h5);
    fin(8'hc0);
    go(CMD_BLANK, 13'h0);
    fin(8'hc0);
    wr(OFS_PROT, 32'h0);
    go(CMD_PAGE, 13'h1e00);
    fin(8'he0);
    wr(OFS_STATUS, 32'h10);
    st(8'he0);
    wr(OFS_STATUS, 32'h20);
    st(8'hc0);
    wr(OFS_PROT, 32'h1);
    lat <= 8'h3c;
    go(CMD_BURST, 13'h10);
    go(CMD_BURST, 13'h11);
    st(8'h00);
    fin(8'hc0);
    go(CMD_PAGE, 13'h0);
    stop_req <= 1'b1;
    @(posedge aclk);
    stop_req <= 1'b0;
    fin(8'hd0);
    tally_and_finish();
  end
endmodule

/* File: tb/flash_command_status_control_monitor.sv */
/*
  checker on the top ports of the flash command/status block.
  assumes one clock aclk and synchronous active-low aresetn.
*/
`timescale 1ns/1ns
module flash_command_status_control_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic arr_req,
  input wire logic arr_ack,
  input wire flash_pkg::arr_op_t arr_op,
  input wire logic [12:0] arr_addr,
  input wire logic [7:0] arr_wdata,
  input wire logic [1:0] security_state_code
);
  import flash_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  rd_answer_a:
    assert property (s_rd_take |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered");
  rdata_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  unmapped_rd_a:
    assert property (s_rd_take ##0 (s_axi_araddr > OFS_SEC) |=>
      s_axi_rresp == RESP_SLVERR && s_axi_rdata == RDATA_ZERO)
    else $error("unmapped read not refused");
  busy_done_a:
    assert property (s_rd_take ##0 (s_axi_araddr == OFS_STATUS && arr_req)
      |=> !s_axi_rdata[BIT_CCF]) else $error("complete while busy");
  arr_hold_a:
    assert property (arr_req && !arr_ack |=> arr_req && $stable(arr_op)
      && $stable(arr_addr) && $stable(arr_wdata))
    else $error("array request moved");
  blank_step_a:
    assert property (arr_req && arr_ack && arr_op == ARR_READ &&
      arr_addr != ARR_LAST |=> arr_req && arr_addr == $past(arr_addr) +
      ARR_STEP) else $error("blank scan skipped");
  blank_first_a:
    assert property ($rose(arr_req) && arr_op == ARR_READ |->
      arr_addr == ARR_FIRST) else $error("blank scan start");
  unsecure_a:
    assert property ($changed(security_state_code) |->
      security_state_code == SEC_UNSECURED) else $error("bad security");
endmodule
bind flash_command_status_control flash_command_status_control_monitor
  flash_command_status_control_monitor_inst (.*);
